// ===== cpu_model.sv
/* cpu model: boundaries every fourth cycle, takes offered vectors.
   assumes the clock of exc_ctrl. */
`timescale 1ns/1ps
module cpu_model (
  input  wire clk_sys,
  input  wire rst,
  input  wire slow,
  input  wire resetVectorReq,
  input  wire vectorValid,
  output reg  instrBoundary,
  output reg  takeVector
);
  reg [1:0] phase;
  // ====================
  // sequencing
  // slow mode waits for a phase to stretch each offer
  always @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      phase <= 2'h0;
      instrBoundary <= 1'h0;
      takeVector <= 1'h0;
    end
    else
    begin
      phase <= phase + 2'h1;
      instrBoundary <= phase == 2'h3;
      takeVector <= (resetVectorReq || vectorValid) && !takeVector && (!slow || phase == 2'h3);
    end
endmodule

// ===== exc_ctrl.v
/*
  exception priority and vectoring: nmi and eight external requests,
  24 internal slots (two reserved), mask bit, vector output to the cpu.
  assumes the cpu pulses instrBoundary at each instruction end and
  takeVector for one cycle when it latches the offered vector.
*/
`timescale 1ns/1ps
`include "exc_ctrl_defs.vh"
module exc_ctrl #(
  parameter NUM_EXT = 8
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        chipResetInputN,
  input  wire        nmiLineN,
  input  wire [7:0]  externalRequestLinesN,
  input  wire [23:0] internalRequests,
  input  wire        instrBoundary,
  input  wire        takeVector,
  input  wire        maskWrite,
  input  wire        maskWriteValue,
  output reg         resetVectorReq,
  output wire        vectorValid,
  output reg  [5:0]  vectorNumber,
  output reg  [15:0] vectorAddress,
  output reg         maskBit,
  output reg         firstInstrDone,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ==========================================================
  // reset and configuration registers
  // ==========================================================
  // chip pin and bench reset share one asynchronous path
  wire        anyReset = reset | ~chipResetInputN; // [RULE1] [RULE3]
  reg  [7:0]  systemControl;
  reg  [7:0]  externalSenseSelect;
  reg  [7:0]  externalRequestEnable;
  reg  [7:0]  extPending;
  reg  [23:0] intPending;
  reg         nmiPending;
  reg         nmiPrev;
  reg  [7:0]  extPrev;
  reg         awHeld;
  reg         wHeld;
  reg  [31:0] awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;

  function [15:0] tableAddr;
    input [5:0] vec;
    begin
      tableAddr = {9'h000, vec, 1'b0}; // [RULE14]
    end
  endfunction

  // ==========================================================
  // request detection
  // ==========================================================
  wire        nmiEdgeSel = systemControl[`BIT_NMI_EDGE];
  wire        nmiEvent = nmiEdgeSel ? (nmiLineN & ~nmiPrev) : (~nmiLineN & nmiPrev); // [RULE13]
  // edges are seen against last cycle's pin sample
  wire [7:0]  extFall = extPrev & ~externalRequestLinesN;
  wire [7:0]  extLevel = ~externalRequestLinesN & ~externalSenseSelect & externalRequestEnable; // [RULE18]
  wire [7:0]  extEdgeSet = extFall & externalSenseSelect & externalRequestEnable; // [RULE12] [RULE19]
  // reserved slots never raise a request
  wire [23:0] intLive = internalRequests & 24'hFF9FFF; // [RULE15] [RULE16]
  wire [7:0]  extActive = extPending | extLevel;
  wire [23:0] intActive = intPending | intLive; // [RULE9]
  // pending edges clear when masked, level and disabled
  wire [7:0]  extClear = {8{maskBit}} & ~externalSenseSelect & ~externalRequestEnable;

  // ==========================================================
  // priority arbiter
  // ==========================================================
  reg        pickFound;
  reg [5:0]  pickVec;
  integer    i;
  always @*
  begin
    pickFound = 1'b0;
    pickVec = `VEC_NMI;
    if (nmiPending)
    begin
      pickFound = 1'b1; // [RULE11]
    end
    else if (!maskBit)
    begin
      // downward scan: the lowest vector is written last and wins
      for (i = NUM_EXT + `NUM_INT_SLOTS - 1; i >= 0; i = i - 1)
      begin
        if (i < NUM_EXT)
        begin
          if (extActive[i])
          begin
            pickFound = 1'b1;
            pickVec = `VEC_EXT_BASE + i[5:0]; // [RULE10]
          end
        end
        else if (intActive[i - NUM_EXT])
        begin
          pickFound = 1'b1;
          pickVec = `VEC_EXT_BASE + i[5:0]; // [RULE10]
        end
      end
    end
  end

  reg offered;
  // boundary gating; nothing before the first instruction ends
  assign vectorValid = offered;

  // ==========================================================
  // exception sequencing
  // ==========================================================
  wire takeNow = offered & takeVector;
  // only the taken source clears; every other request stays pending
  wire [7:0]  takenExt = (takeNow && vectorNumber >= `VEC_EXT_BASE && vectorNumber < `VEC_INT_BASE) ?
                          (8'h01 << (vectorNumber - `VEC_EXT_BASE)) : 8'h00;
  wire [23:0] takenInt = (takeNow && vectorNumber >= `VEC_INT_BASE) ?
                          (24'h000001 << (vectorNumber - `VEC_INT_BASE)) : 24'h000000;

  always @(posedge clk_sys or posedge anyReset)
  begin
    if (anyReset)
    begin
      maskBit <= 1'b1; // [RULE6]
      resetVectorReq <= 1'b1; // [RULE1] [RULE7]
      firstInstrDone <= 1'b0;
      offered <= 1'b0;
      vectorNumber <= `VEC_RESET;
      vectorAddress <= 16'h0000;
      nmiPending <= 1'b0;
      nmiPrev <= 1'b1;
      extPrev <= 8'hFF;
      extPending <= 8'h00;
      intPending <= 24'h000000;
    end
    else
    begin
      nmiPrev <= nmiLineN;
      extPrev <= externalRequestLinesN;
      if (resetVectorReq && takeVector)
      begin
        resetVectorReq <= 1'b0;
      end
      if (!resetVectorReq && instrBoundary)
      begin
        firstInstrDone <= 1'b1; // [RULE8]
      end
      // set wins over clear on every pending flag
      nmiPending <= nmiEvent | (nmiPending & ~(takeNow && vectorNumber == `VEC_NMI));
      extPending <= extEdgeSet | (extPending & ~takenExt & ~extClear); // [RULE21]
      intPending <= intLive | (intPending & ~takenInt); // [RULE21]
      if (takeNow)
      begin
        offered <= 1'b0;
        maskBit <= 1'b1; // [RULE20]
      end
      else
      begin
        if (maskWrite)
        begin
          maskBit <= maskWriteValue;
        end
        // vector frozen once offered; a later, higher request waits for the next offer
        if (!offered && firstInstrDone && instrBoundary && pickFound)
        begin
          offered <= 1'b1; // [RULE2]
          vectorNumber <= pickVec;
          vectorAddress <= tableAddr(pickVec);
        end
      end
      if (resetVectorReq)
      begin
        vectorAddress <= tableAddr(`VEC_RESET); // [RULE7]
      end
    end
  end

  // ==========================================================
  // axi4-lite slave
  // ==========================================================
  // readies drop while a response waits, so one write is under way at a time
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire [31:0] curAw = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] curW = wHeld ? wData : s_axi_wdata;
  wire [3:0]  curS = wHeld ? wStrb : s_axi_wstrb;
  wire        haveAw = awHeld | s_axi_awvalid;
  wire        haveW = wHeld | s_axi_wvalid;
  wire        doWrite = haveAw & haveW & ~s_axi_bvalid;
  // byte registers sit in the lane of their byte address within the one shared aligned word
  wire [15:0] wAddr = {curAw[15:2], 2'b00};
  wire [15:0] rAddr = {s_axi_araddr[15:2], 2'b00};

  // aligned word addresses; the three byte registers share one word
  localparam [15:0] WORD_CONTROL = `ADDR_SYSTEM_CONTROL & 16'hFFFC;
  localparam [15:0] WORD_MASK    = `ADDR_CONDITION_CODE;
  localparam [15:0] WORD_EXT     = `ADDR_PENDING_EXT;
  localparam [15:0] WORD_INT     = `ADDR_PENDING_INT;

  function mapped;
    input [15:0] a;
    begin
      mapped = (a == WORD_CONTROL) || (a == WORD_MASK) ||
               (a == WORD_EXT) || (a == WORD_INT);
    end
  endfunction

  always @(posedge clk_sys or posedge anyReset)
  begin
    if (anyReset)
    begin
      systemControl <= `RST_SYSTEM_CONTROL; // [RULE3]
      externalSenseSelect <= `RST_SENSE_SELECT;
      externalRequestEnable <= `RST_REQUEST_ENABLE; // [RULE19]
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 32'h00000000;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !doWrite)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !doWrite)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wAddr) ? 2'b00 : 2'b10;
        // bit 3 reads as one always [RULE17]
        if (wAddr == (`ADDR_SYSTEM_CONTROL & 16'hFFFC) && curS[0])
        begin
          systemControl <= curW[7:0] | 8'h08;
        end
        if (wAddr == (`ADDR_SENSE_SELECT & 16'hFFFC) && curS[2])
        begin
          externalSenseSelect <= curW[23:16];
        end
        if (wAddr == (`ADDR_REQUEST_ENABLE & 16'hFFFC) && curS[3])
        begin
          externalRequestEnable <= curW[31:24];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(rAddr) ? 2'b00 : 2'b10;
        // sense and enable share the control word in lanes 2 and 3
        case (rAddr)
          WORD_CONTROL:
            s_axi_rdata <= {externalRequestEnable, externalSenseSelect, 8'h00, systemControl}; // [RULE17]
          WORD_MASK: s_axi_rdata <= {24'h000000, maskBit, 7'h00};
          WORD_EXT: s_axi_rdata <= {23'h0, nmiPending, extActive};
          WORD_INT: s_axi_rdata <= {8'h00, intActive};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== exc_ctrl_checker.sv
/* port checks for exc_ctrl.
   assumes a bind from the bench top, one clock. */
`timescale 1ns/1ps
module exc_ctrl_checker (
  input wire        clk_sys,
  input wire        reset,
  input wire        chipResetInputN,
  input wire        instrBoundary,
  input wire        takeVector,
  input wire        resetVectorReq,
  input wire        vectorValid,
  input wire [5:0]  vectorNumber,
  input wire [15:0] vectorAddress,
  input wire        maskBit,
  input wire        firstInstrDone
);
  // ====================
  // assertions
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset || !chipResetInputN);
  chk_reset_hold: assert property (disable iff (1'h0) (reset || !chipResetInputN) |-> maskBit && resetVectorReq)
    else $error("reset state lost");
  chk_reset_first: assert property (resetVectorReq |-> !vectorValid && vectorAddress == 16'h0000)
    else $error("offer beside reset vector");
  chk_vec_addr: assert property (vectorValid |-> vectorAddress == {9'h000, vectorNumber, 1'h0})
    else $error("vector address wrong");
  chk_vec_range: assert property (vectorValid |-> vectorNumber inside {[6'h03:6'h18], [6'h1B:6'h23]})
    else $error("vector number out of range");
  chk_mask_obey: assert property ($rose(vectorValid) && vectorNumber != 6'h03 |-> !$past(maskBit))
    else $error("masked offer");
  chk_at_boundary: assert property ($rose(vectorValid) |-> $past(instrBoundary) && $past(firstInstrDone))
    else $error("offer off boundary");
  chk_take_mask: assert property (vectorValid && takeVector |=> maskBit && !vectorValid)
    else $error("take did not mask");
  chk_offer_holds: assert property (vectorValid && !takeVector |=> vectorValid && $stable(vectorNumber))
    else $error("offer dropped");
endmodule

// ===== exc_ctrl_defs.vh
/*
  constants for the exception priority and vectoring block.
  assumes inclusion by bare name from exc_ctrl.v; definitions only.
*/
// Notes on behaviour
// RULE1: reset beats interrupts; vector fetch on release
// RULE2: interrupts taken only at instruction boundaries
// RULE3: reset low holds all state initial
// RULE4: runtime reset held low ten clocks
// RULE5: power-up reset held low twenty milliseconds; the bench holds reset 12 clocks
// RULE6: mask bit set on leaving reset
// RULE7: reset loads program counter from address zero
// RULE8: no interrupt before first instruction completes
// RULE9: nine external plus 22 internal sources
// RULE10: fixed priority, lower vector number wins
// RULE11: nonmaskable ignores mask; others obey it
// RULE12: per-input edge or level sensing
// RULE13: nonmaskable edge chosen by control bit 2
// RULE14: vector n entry at byte 2n
// RULE15: internal sources fill vectors 12 to 35
// RULE16: bytes 2 to 5 never used as vectors
// RULE17: configuration from three byte registers
// RULE18: sense bit 0 level, 1 falling edge
// RULE19: enable bit 1 enables; reset clears
// RULE20: accepting a request sets mask bit
// RULE21: pending requests held until accepted or cleared
`ifndef EXC_CTRL_DEFS_VH
`define EXC_CTRL_DEFS_VH
`define ADDR_SYSTEM_CONTROL    16'hFFC4
`define ADDR_SENSE_SELECT      16'hFFC6
`define ADDR_REQUEST_ENABLE    16'hFFC7
`define ADDR_CONDITION_CODE    16'hFFC8
`define ADDR_PENDING_EXT       16'hFFCC
`define ADDR_PENDING_INT       16'hFFD0
`define RST_SYSTEM_CONTROL     8'h09
`define RST_SENSE_SELECT       8'h00
`define RST_REQUEST_ENABLE     8'h00
`define BIT_NMI_EDGE           2
`define BIT_MASK               7
`define VEC_RESET              6'h00
`define VEC_NMI                6'h03
`define VEC_EXT_BASE           6'h04
`define VEC_INT_BASE           6'h0C
`define VEC_RESERVED_LO        6'h19
`define VEC_RESERVED_HI        6'h1A
`define VEC_LAST               6'h23
`define NUM_INT_SLOTS          24
`endif

// ===== exc_ctrl_test.sv
/* bench for exc_ctrl with cpu_model and checker.
   assumes both compiled before this file. */
`timescale 1ns/1ps
module exc_ctrl_test;
  reg         clk_sys = 1'h0;
  reg         reset = 1'h0;
  reg         chipResetInputN = 1'h1;
  reg         nmiLineN = 1'h1;
  reg  [7:0]  externalRequestLinesN = 8'hFF;
  reg  [23:0] internalRequests = 24'h0;
  reg         maskWrite = 1'h0;
  reg         maskWriteValue = 1'h0;
  reg         slow = 1'h0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rdat;
  reg  [3:0]  s_axi_wstrb = 4'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg  [1:0]  resp;
  wire        instrBoundary, takeVector, resetVectorReq, vectorValid, maskBit, firstInstrDone;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [5:0]  vectorNumber;
  wire [15:0] vectorAddress;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     n_fail = 0, cmp_count = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  exc_ctrl exc_ctrl_i (.clk_sys, .reset, .chipResetInputN, .nmiLineN, .externalRequestLinesN, .internalRequests,
    .instrBoundary, .takeVector, .maskWrite, .maskWriteValue, .resetVectorReq, .vectorValid, .vectorNumber,
    .vectorAddress, .maskBit, .firstInstrDone, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cpu_model cpu_model_i (.clk_sys, .rst(reset || !chipResetInputN), .slow, .resetVectorReq, .vectorValid,
    .instrBoundary, .takeVector);
  // ====================
  // helpers
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e, input string nm);
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("BAD %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  // one transfer; readies looked at mid-cycle, acted on at the edge
  task bus(input w, input [31:0] a, input [31:0] d, input [3:0] s);
    reg ta, tw, dn;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    dn = 0;
    while (!dn)
    begin
      @(negedge clk_sys);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'h0;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    @(posedge clk_sys);
  endtask
  task mask(input v);
    maskWrite <= 1'h1;
    maskWriteValue <= v;
    @(posedge clk_sys);
    maskWrite <= 1'h0;
    @(posedge clk_sys);
  endtask
  task quiet;
    repeat (20) @(negedge clk_sys);
    chk(vectorValid, 1'h0, "no offer");
    @(posedge clk_sys);
  endtask
  task serve(input [5:0] v);
    integer n;
    n = 0;
    while (vectorValid !== 1'h1 && n < 300) @(negedge clk_sys) n = n + 1;
    chk(vectorNumber, v, "vecnum");
    chk(vectorAddress, {v, 1'h0}, "vecaddr");
    while (takeVector !== 1'h1 && n < 600) @(negedge clk_sys) n = n + 1;
    @(posedge clk_sys);
    if (v > 6'h03 && v < 6'h0C) externalRequestLinesN[v - 6'h04] <= 1'h1;
    @(negedge clk_sys);
    chk(maskBit, 1'h1, "mask after take");
    repeat (4) @(posedge clk_sys);
    mask(1'h0);
  endtask
  // ====================
  // scenarios
  task boot;
    integer k;
    k = 0;
    @(negedge clk_sys);
    chk(resetVectorReq, 1'h1, "reset req");
    chk(vectorAddress, 16'h0, "reset addr");
    chk(maskBit, 1'h1, "mask at reset");
    while (firstInstrDone !== 1'h1 && k < 100) @(negedge clk_sys) k = k + 1;
    chk(firstInstrDone, 1'h1, "first instr");
    @(posedge clk_sys);
  endtask
  task t_regs;
    bus(1'h0, 32'hFFC4, 32'h0, 4'h0);
    chk(rdat, 32'h00000009, "cfg word");
    bus(1'h1, 32'hFF00, 32'h0, 4'hF);
    chk(resp, 2'h2, "bad wr");
    bus(1'h0, 32'hFF00, 32'h0, 4'h0);
    chk(resp, 2'h2, "bad rd resp");
    chk(rdat, 32'h0, "bad rd data");
    bus(1'h0, 32'hFFC8, 32'h0, 4'h0);
    chk(rdat, 32'h00000080, "mask word");
  endtask
  task t_nmi;
    nmiLineN <= 1'h0;
    serve(6'h03);
    bus(1'h1, 32'hFFC4, 32'h4, 4'h1);
    chk(resp, 2'h0, "wr resp");
    bus(1'h0, 32'hFFC4, 32'h0, 4'h0);
    chk(rdat[7:0], 8'h0C, "ctl byte");
    nmiLineN <= 1'h1;
    serve(6'h03);
    nmiLineN <= 1'h0;
    quiet;
    bus(1'h1, 32'hFFC4, 32'h9, 4'h1);
    nmiLineN <= 1'h1;
  endtask
  task t_prio;
    integer v;
    mask(1'h1);
    bus(1'h1, 32'hFFC4, 32'hFF000000, 4'h8);
    externalRequestLinesN <= 8'h7E;
    internalRequests <= 24'h802001;
    @(posedge clk_sys);
    internalRequests <= 24'h0;
    quiet;
    bus(1'h0, 32'hFFCC, 32'h0, 4'h0);
    chk(rdat, 32'h00000081, "ext pending");
    bus(1'h0, 32'hFFD0, 32'h0, 4'h0);
    chk(rdat, 32'h00800001, "int pending");
    mask(1'h0);
    serve(6'h04);
    serve(6'h0B);
    serve(6'h0C);
    serve(6'h23);
    quiet;
    slow <= 1'h1;
    for (v = 4; v < 36; v = v + 1)
      if (v < 25 || v > 26)
      begin
        if (v < 12) externalRequestLinesN[v - 4] <= 1'h0;
        else internalRequests[v - 12] <= 1'h1;
        @(posedge clk_sys);
        internalRequests <= 24'h0;
        serve(v[5:0]);
      end
    slow <= 1'h0;
  endtask
  task t_ext;
    bus(1'h1, 32'hFFC4, 32'h0, 4'h8);
    externalRequestLinesN <= 8'hFD;
    quiet;
    externalRequestLinesN <= 8'hFF;
    mask(1'h1);
    bus(1'h1, 32'hFFC4, 32'h04040000, 4'hC);
    externalRequestLinesN <= 8'hFB;
    repeat (3) @(posedge clk_sys);
    externalRequestLinesN <= 8'hFF;
    mask(1'h0);
    serve(6'h06);
    quiet;
  endtask
  task t_rst;
    chipResetInputN <= 1'h0;
    repeat (10) @(posedge clk_sys);
    chk({maskBit, resetVectorReq, vectorValid}, 3'h6, "in reset");
    chipResetInputN <= 1'h1;
    boot;
    bus(1'h0, 32'hFFC4, 32'h0, 4'h0);
    chk(rdat, 32'h00000009, "cfg after reset");
  endtask
  initial
  begin
    reset <= 1'h1;
    // power-up hold cut to 12 cycles; a board holds it far longer
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    boot;
    t_regs;
    t_nmi;
    t_prio;
    t_ext;
    t_rst;
    end_sim;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
endmodule
bind exc_ctrl exc_ctrl_checker exc_ctrl_checker_i (.clk_sys, .reset, .chipResetInputN, .instrBoundary, .takeVector,
  .resetVectorReq, .vectorValid, .vectorNumber, .vectorAddress, .maskBit, .firstInstrDone);
